// *** hw/irq_rate_pkg.sv ***
/*
 * Package for the module interrupt mask and rate select register bank:
 * byte offsets, field positions, reset values, rate codes and carriers.
 * Assumes a 32-bit APB slave where each management byte takes one word.
 */
package irq_rate_pkg;

    // Management byte indices; byte address is four times the index
    localparam logic [7:0] IDX_RX_RATE   = 8'h57;
    localparam logic [7:0] IDX_TX_RATE   = 8'h58;
    localparam logic [7:0] IDX_LOS_MASK  = 8'h64;
    localparam logic [7:0] IDX_FLT_MASK  = 8'h65;
    localparam logic [7:0] IDX_RSV_MASK  = 8'h66;
    localparam logic [7:0] IDX_TEMP_MASK = 8'h67;
    localparam logic [7:0] IDX_VCC_MASK  = 8'h68;
    localparam logic [7:0] IDX_CAP_CTRL  = 8'hF0;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'hF1;
    localparam logic [7:0] IDX_IRQ_EN    = 8'hF2;
    localparam logic [7:0] IDX_APP_MODE  = 8'hF3;

    // Writable bits of each mask byte; reserved bits read zero
    localparam logic [7:0] LOS_MASK_BITS  = 8'hFF;
    localparam logic [7:0] FLT_MASK_BITS  = 8'h0F;
    localparam logic [7:0] TEMP_MASK_BITS = 8'hF1;
    localparam logic [7:0] VCC_MASK_BITS  = 8'hF0;

    localparam logic [7:0] MASK_RESET     = 8'h00;
    localparam logic [7:0] RATE_RESET     = 8'h00;

    // Capability control register fields
    localparam int CAP_SW_RATE_BIT  = 0;
    localparam int CAP_DECL_LO_BIT  = 2;
    localparam int CAP_DECL_HI_BIT  = 3;
    localparam int CAP_OPT_RATE_BIT = 5;
    // Capability bits that stay writable while rate support is declared
    localparam logic [7:0] CAP_WRITE_BITS = 8'h2D;

    // Extended rate compliance value, the only one reported
    localparam logic [7:0] EXT_RATE_COMPLIANCE = 8'h01;

    // Event status bits
    localparam int EV_IRQ_RISE = 0;
    localparam int EV_RATE_WR  = 1;
    localparam int EV_RSV_CODE = 2;

    typedef enum logic [1:0] {
        RATE_LOW = 2'b00,
        RATE_MID = 2'b01,
        RATE_HIGH = 2'b10,
        RATE_RSVD = 2'b11
    } rate_code_t;

    // Latched flags in the same layout as the mask bytes
    typedef struct packed {
        logic [7:0] los;
        logic [7:0] fault;
        logic [7:0] temp;
        logic [7:0] vcc;
    } flag_set_t;

    typedef struct packed {
        logic [3:0][1:0] rx;
        logic [3:0][1:0] tx;
        logic [3:0]      rx_valid;
        logic [3:0]      tx_valid;
    } rate_out_t;

endpackage

// *** hw/irq_rate_bank.sv ***
/*
 * Interrupt mask and per-channel rate select register bank of a
 * four-channel pluggable transceiver, reached over APB.
 * Assumes latched flags arrive on clk from the flag logic, and that the
 * rate outputs feed the channel receive filters and transmit tuning.
 */
`timescale 1ns/100ps

module irq_rate_bank (
    input  wire logic                    clk,             // 250 MHz clock
    input  wire logic                    resetn,          // Async reset, active low
    input  wire logic                    psel,            // APB select
    input  wire logic                    penable,         // APB access phase
    input  wire logic                    pwrite,          // APB write
    input  wire logic [11:0]             paddr,           // APB byte address
    input  wire logic [31:0]             pwdata,          // APB write data
    output logic                         pready,          // APB ready
    output logic [31:0]                  prdata,          // APB read data
    output logic                         pslverr,         // APB error
    input  wire irq_rate_pkg::flag_set_t latched_flags,   // Latched module flags
    output logic                         interrupt_out_n, // Module interrupt, low active
    output logic                         irq,             // Block event interrupt
    output irq_rate_pkg::rate_out_t      rate_sel         // Per-channel rate control
);

    typedef struct packed {
        logic [7:0]                rx_rate;
        logic [7:0]                tx_rate;
        logic [7:0]                los_mask;
        logic [7:0]                flt_mask;
        logic [7:0]                temp_mask;
        logic [7:0]                vcc_mask;
        logic [7:0]                cap;
        logic [7:0]                app_mode;
        logic [2:0]                status;
        logic [2:0]                enable;
        logic                      pending;
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
        logic                      interrupt_out_n_n;
        logic                      irq;
        irq_rate_pkg::rate_out_t   rate;
    } state_t;

    state_t     state_q;
    state_t     state_d;
    logic [9:0] idx;
    logic       acc;
    logic       wr;
    logic       hit;
    logic [7:0] rdbyte;
    logic       ext_mode;
    logic       unmasked;
    logic [2:0] events;
    logic [3:0] ch_on;

    // Compliance constant never reports a reserved value
    localparam logic [7:0] COMPLIANCE = irq_rate_pkg::EXT_RATE_COMPLIANCE;

    assign idx = paddr[11:2];
    assign acc = psel && !penable;
    assign wr  = acc && pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Read decode; reserved bits and the reserved byte read zero

    always_comb begin
        hit    = 1'b1;
        rdbyte = 8'h00;
        if (idx == {2'b00, irq_rate_pkg::IDX_RX_RATE}) begin
            rdbyte = state_q.rx_rate;
        end else if (idx == {2'b00, irq_rate_pkg::IDX_TX_RATE}) begin
            rdbyte = state_q.tx_rate;
        end else if (idx == {2'b00, irq_rate_pkg::IDX_LOS_MASK}) begin
            rdbyte = state_q.los_mask;
        end else if (idx == {2'b00, irq_rate_pkg::IDX_FLT_MASK}) begin
            rdbyte = state_q.flt_mask;
        end else if (idx == {2'b00, irq_rate_pkg::IDX_RSV_MASK}) begin
            rdbyte = 8'h00;
        end else if (idx == {2'b00, irq_rate_pkg::IDX_TEMP_MASK}) begin
            rdbyte = state_q.temp_mask;
        end else if (idx == {2'b00, irq_rate_pkg::IDX_VCC_MASK}) begin
            rdbyte = state_q.vcc_mask;
        end else if (idx == {2'b00, irq_rate_pkg::IDX_CAP_CTRL}) begin
            rdbyte = state_q.cap;
        end else if (idx == {2'b00, irq_rate_pkg::IDX_IRQ_STAT}) begin
            rdbyte = {5'h00, state_q.status};
        end else if (idx == {2'b00, irq_rate_pkg::IDX_IRQ_EN}) begin
            rdbyte = {5'h00, state_q.enable};
        end else if (idx == {2'b00, irq_rate_pkg::IDX_APP_MODE}) begin
            rdbyte = state_q.app_mode;
        end else begin
            hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt gating and rate decoding

    always_comb begin
        // Extended mode needs declaration bits 3:2 = 10 with software rate select on
        ext_mode = state_q.cap[irq_rate_pkg::CAP_SW_RATE_BIT]
                 && !state_q.cap[irq_rate_pkg::CAP_DECL_LO_BIT]
                 && state_q.cap[irq_rate_pkg::CAP_DECL_HI_BIT]
                 && COMPLIANCE[0];
        unmasked = |(latched_flags.los   & ~state_q.los_mask  & irq_rate_pkg::LOS_MASK_BITS)
                 | |(latched_flags.fault & ~state_q.flt_mask  & irq_rate_pkg::FLT_MASK_BITS)
                 | |(latched_flags.temp  & ~state_q.temp_mask & irq_rate_pkg::TEMP_MASK_BITS)
                 | |(latched_flags.vcc   & ~state_q.vcc_mask  & irq_rate_pkg::VCC_MASK_BITS);
        for (int c = 0; c < 4; c++) begin
            ch_on[c] = ext_mode && !state_q.app_mode[c];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_d         = state_q;
        events          = 3'b000;
        state_d.pready  = 1'b0;
        state_d.pslverr = 1'b0;
        if (acc) begin
            state_d.pready  = 1'b1;
            state_d.pslverr = !hit;
            state_d.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rdbyte};
        end
        if (wr && hit) begin
            if (idx == {2'b00, irq_rate_pkg::IDX_RX_RATE}) begin
                state_d.rx_rate = pwdata[7:0];
                events[irq_rate_pkg::EV_RATE_WR] = 1'b1;
            end else if (idx == {2'b00, irq_rate_pkg::IDX_TX_RATE}) begin
                state_d.tx_rate = pwdata[7:0];
                events[irq_rate_pkg::EV_RATE_WR] = 1'b1;
            end else if (idx == {2'b00, irq_rate_pkg::IDX_LOS_MASK}) begin
                state_d.los_mask = pwdata[7:0] & irq_rate_pkg::LOS_MASK_BITS;
            end else if (idx == {2'b00, irq_rate_pkg::IDX_FLT_MASK}) begin
                state_d.flt_mask = pwdata[7:0] & irq_rate_pkg::FLT_MASK_BITS;
            end else if (idx == {2'b00, irq_rate_pkg::IDX_TEMP_MASK}) begin
                state_d.temp_mask = pwdata[7:0] & irq_rate_pkg::TEMP_MASK_BITS;
            end else if (idx == {2'b00, irq_rate_pkg::IDX_VCC_MASK}) begin
                state_d.vcc_mask = pwdata[7:0] & irq_rate_pkg::VCC_MASK_BITS;
            end else if (idx == {2'b00, irq_rate_pkg::IDX_CAP_CTRL}) begin
                // Declaration bits and option bit only show with rate support
                state_d.cap = pwdata[irq_rate_pkg::CAP_SW_RATE_BIT]
                            ? (pwdata[7:0] & irq_rate_pkg::CAP_WRITE_BITS) : 8'h00;
            end else if (idx == {2'b00, irq_rate_pkg::IDX_IRQ_STAT}) begin
                state_d.status = state_q.status & ~pwdata[2:0];
            end else if (idx == {2'b00, irq_rate_pkg::IDX_IRQ_EN}) begin
                state_d.enable = pwdata[2:0];
            end else if (idx == {2'b00, irq_rate_pkg::IDX_APP_MODE}) begin
                state_d.app_mode = {4'h0, pwdata[3:0]};
            end
        end
        state_d.interrupt_out_n_n = !unmasked;
        events[irq_rate_pkg::EV_IRQ_RISE] = unmasked && state_q.interrupt_out_n_n;
        for (int c = 0; c < 4; c++) begin
            state_d.rate.rx[c] = ch_on[c] ? state_q.rx_rate[2*c +: 2] : 2'b00;
            state_d.rate.tx[c] = ch_on[c] ? state_q.tx_rate[2*c +: 2] : 2'b00;
            // Code 11 is reserved and never used as a valid rate
            state_d.rate.rx_valid[c] = ch_on[c]
                && (state_q.rx_rate[2*c +: 2] != irq_rate_pkg::RATE_RSVD);
            state_d.rate.tx_valid[c] = ch_on[c]
                && (state_q.tx_rate[2*c +: 2] != irq_rate_pkg::RATE_RSVD);
            if (ch_on[c] && ((state_q.rx_rate[2*c +: 2] == irq_rate_pkg::RATE_RSVD)
                || (state_q.tx_rate[2*c +: 2] == irq_rate_pkg::RATE_RSVD))) begin
                events[irq_rate_pkg::EV_RSV_CODE] = 1'b1;
            end
        end
        // Set wins over a clear in the same cycle
        state_d.status = state_d.status | events;
        state_d.irq    = |(state_d.status & state_d.enable);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q           <= '0;
            state_q.los_mask  <= irq_rate_pkg::MASK_RESET;
            state_q.flt_mask  <= irq_rate_pkg::MASK_RESET;
            state_q.temp_mask <= irq_rate_pkg::MASK_RESET;
            state_q.vcc_mask  <= irq_rate_pkg::MASK_RESET;
            state_q.rx_rate   <= irq_rate_pkg::RATE_RESET;
            state_q.tx_rate   <= irq_rate_pkg::RATE_RESET;
            state_q.interrupt_out_n_n    <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign pready          = state_q.pready;
    assign prdata          = state_q.prdata;
    assign pslverr         = state_q.pslverr;
    assign interrupt_out_n = state_q.interrupt_out_n_n;
    assign irq             = state_q.irq;
    assign rate_sel        = state_q.rate;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_pin_follows_flags: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> (interrupt_out_n == !$past(unmasked)))
        else $error("interrupt pin does not follow unmasked flags");

    a_full_mask_quiet: assert property (@(posedge clk) disable iff (!resetn)
        (state_q.los_mask == 8'hFF && state_q.flt_mask[3:0] == 4'hF
         && state_q.temp_mask == 8'hF1 && state_q.vcc_mask == 8'hF0)
        |=> interrupt_out_n)
        else $error("masked flags still assert interrupt pin");

    a_fault_rsvd_zero: assert property (@(posedge clk) disable iff (!resetn)
        state_q.flt_mask[7:4] == 4'h0)
        else $error("reserved fault mask bits set");

    a_temp_rsvd_zero: assert property (@(posedge clk) disable iff (!resetn)
        state_q.temp_mask[3:1] == 3'h0)
        else $error("reserved temperature mask bits set");

    a_vcc_rsvd_zero: assert property (@(posedge clk) disable iff (!resetn)
        state_q.vcc_mask[3:0] == 4'h0)
        else $error("reserved supply mask bits set");

    a_los_write_takes: assert property (@(posedge clk) disable iff (!resetn)
        (wr && idx == {2'b00, irq_rate_pkg::IDX_LOS_MASK})
        |=> (state_q.los_mask == $past(pwdata[7:0])))
        else $error("signal loss mask write lost");

    a_no_rate_caps: assert property (@(posedge clk) disable iff (!resetn)
        !state_q.cap[0] |-> (state_q.cap == 8'h00))
        else $error("rate capability reported without support");

    a_rate_ignored: assert property (@(posedge clk) disable iff (!resetn)
        !$past(ch_on[0]) |-> (rate_sel.rx[0] == 2'b00 && !rate_sel.rx_valid[0]))
        else $error("rate field used while ignored");

    a_rate_passes: assert property (@(posedge clk) disable iff (!resetn)
        $past(ch_on[1]) |-> (rate_sel.tx[1] == $past(state_q.tx_rate[3:2])))
        else $error("transmit rate field not applied");

    a_compliance_ok: assert property (@(posedge clk) disable iff (!resetn)
        !((rate_sel.rx_valid[0] && rate_sel.rx[0] == irq_rate_pkg::RATE_RSVD)
          || (rate_sel.rx_valid[1] && rate_sel.rx[1] == irq_rate_pkg::RATE_RSVD)
          || (rate_sel.rx_valid[2] && rate_sel.rx[2] == irq_rate_pkg::RATE_RSVD)
          || (rate_sel.rx_valid[3] && rate_sel.rx[3] == irq_rate_pkg::RATE_RSVD)))
        else $error("valid receive rate outside compliance table");

    a_tx_code_defined: assert property (@(posedge clk) disable iff (!resetn)
        !((rate_sel.tx_valid[0] && rate_sel.tx[0] == irq_rate_pkg::RATE_RSVD)
          || (rate_sel.tx_valid[1] && rate_sel.tx[1] == irq_rate_pkg::RATE_RSVD)
          || (rate_sel.tx_valid[2] && rate_sel.tx[2] == irq_rate_pkg::RATE_RSVD)
          || (rate_sel.tx_valid[3] && rate_sel.tx[3] == irq_rate_pkg::RATE_RSVD)))
        else $error("valid transmit rate uses reserved code");

    a_flt_write_takes: assert property (@(posedge clk) disable iff (!resetn)
        (wr && idx == {2'b00, irq_rate_pkg::IDX_FLT_MASK})
        |=> (state_q.flt_mask == ($past(pwdata[7:0]) & irq_rate_pkg::FLT_MASK_BITS)))
        else $error("fault mask write lost");

    a_temp_write_takes: assert property (@(posedge clk) disable iff (!resetn)
        (wr && idx == {2'b00, irq_rate_pkg::IDX_TEMP_MASK})
        |=> (state_q.temp_mask == ($past(pwdata[7:0]) & irq_rate_pkg::TEMP_MASK_BITS)))
        else $error("temperature mask write lost");

    a_vcc_write_takes: assert property (@(posedge clk) disable iff (!resetn)
        (wr && idx == {2'b00, irq_rate_pkg::IDX_VCC_MASK})
        |=> (state_q.vcc_mask == ($past(pwdata[7:0]) & irq_rate_pkg::VCC_MASK_BITS)))
        else $error("supply mask write lost");

    a_rx_rate_takes: assert property (@(posedge clk) disable iff (!resetn)
        (wr && idx == {2'b00, irq_rate_pkg::IDX_RX_RATE})
        |=> (state_q.rx_rate == $past(pwdata[7:0])))
        else $error("receive rate write lost");

    a_tx_rate_takes: assert property (@(posedge clk) disable iff (!resetn)
        (wr && idx == {2'b00, irq_rate_pkg::IDX_TX_RATE})
        |=> (state_q.tx_rate == $past(pwdata[7:0])))
        else $error("transmit rate write lost");

    a_rsv_byte_zero: assert property (@(posedge clk) disable iff (!resetn)
        (acc && !pwrite && idx == {2'b00, irq_rate_pkg::IDX_RSV_MASK})
        |=> (prdata == 32'h0000_0000 && pready && !pslverr))
        else $error("reserved byte read not zero");

    a_unmapped_error: assert property (@(posedge clk) disable iff (!resetn)
        (acc && !hit) |=> (pslverr && prdata == 32'h0000_0000))
        else $error("unmapped access not refused");

    a_ch0_tx_ignored: assert property (@(posedge clk) disable iff (!resetn)
        !$past(ch_on[0]) |-> (rate_sel.tx[0] == 2'b00 && !rate_sel.tx_valid[0]))
        else $error("channel 0 transmit rate used while ignored");

    a_ch1_ignored: assert property (@(posedge clk) disable iff (!resetn)
        !$past(ch_on[1]) |-> (rate_sel.rx[1] == 2'b00 && rate_sel.tx[1] == 2'b00
            && !rate_sel.rx_valid[1] && !rate_sel.tx_valid[1]))
        else $error("channel 1 rate used while ignored");

    a_ch2_ignored: assert property (@(posedge clk) disable iff (!resetn)
        !$past(ch_on[2]) |-> (rate_sel.rx[2] == 2'b00 && rate_sel.tx[2] == 2'b00
            && !rate_sel.rx_valid[2] && !rate_sel.tx_valid[2]))
        else $error("channel 2 rate used while ignored");

    a_ch3_ignored: assert property (@(posedge clk) disable iff (!resetn)
        !$past(ch_on[3]) |-> (rate_sel.rx[3] == 2'b00 && rate_sel.tx[3] == 2'b00
            && !rate_sel.rx_valid[3] && !rate_sel.tx_valid[3]))
        else $error("channel 3 rate used while ignored");

    a_ch0_passes: assert property (@(posedge clk) disable iff (!resetn)
        $past(ch_on[0]) |-> (rate_sel.rx[0] == $past(state_q.rx_rate[1:0])
            && rate_sel.tx[0] == $past(state_q.tx_rate[1:0])))
        else $error("channel 0 rate not applied");

    a_ch1_rx_passes: assert property (@(posedge clk) disable iff (!resetn)
        $past(ch_on[1]) |-> (rate_sel.rx[1] == $past(state_q.rx_rate[3:2])))
        else $error("channel 1 receive rate not applied");

    a_ch2_passes: assert property (@(posedge clk) disable iff (!resetn)
        $past(ch_on[2]) |-> (rate_sel.rx[2] == $past(state_q.rx_rate[5:4])
            && rate_sel.tx[2] == $past(state_q.tx_rate[5:4])))
        else $error("channel 2 rate not applied");

    a_ch3_passes: assert property (@(posedge clk) disable iff (!resetn)
        $past(ch_on[3]) |-> (rate_sel.rx[3] == $past(state_q.rx_rate[7:6])
            && rate_sel.tx[3] == $past(state_q.tx_rate[7:6])))
        else $error("channel 3 rate not applied");

    a_init_masked: assert property (@(posedge clk) disable iff (!resetn)
        (state_q.temp_mask[0] && latched_flags == 32'h0000_0100) |=> interrupt_out_n)
        else $error("masked init flag drives pin");

    a_init_unmasked: assert property (@(posedge clk) disable iff (!resetn)
        (!state_q.temp_mask[0] && latched_flags.temp[0]) |=> !interrupt_out_n)
        else $error("unmasked init flag misses pin");

    a_los_reaches_pin: assert property (@(posedge clk) disable iff (!resetn)
        |(latched_flags.los & ~state_q.los_mask) |=> !interrupt_out_n)
        else $error("unmasked signal loss misses pin");

    a_fault_reaches_pin: assert property (@(posedge clk) disable iff (!resetn)
        |(latched_flags.fault[3:0] & ~state_q.flt_mask[3:0]) |=> !interrupt_out_n)
        else $error("unmasked fault misses pin");

    a_cap_cleared: assert property (@(posedge clk) disable iff (!resetn)
        (wr && idx == {2'b00, irq_rate_pkg::IDX_CAP_CTRL} && !pwdata[0]) |=> (state_q.cap == 8'h00))
        else $error("capability kept without rate support");

    a_ext_decl: assert property (@(posedge clk) disable iff (!resetn)
        (|rate_sel.rx_valid || |rate_sel.tx_valid) |-> $past(ext_mode))
        else $error("valid rate outside extended mode");

    a_irq_rise_event: assert property (@(posedge clk) disable iff (!resetn)
        $fell(interrupt_out_n) |-> state_q.status[irq_rate_pkg::EV_IRQ_RISE])
        else $error("pin activation not recorded");

    a_status_sticky: assert property (@(posedge clk) disable iff (!resetn)
        (state_q.status[1] && !(wr && idx == {2'b00, irq_rate_pkg::IDX_IRQ_STAT}))
        |=> state_q.status[1])
        else $error("status bit lost without clear");

endmodule // irq_rate_bank

// *** tb/host_model.sv ***
/*
 * APB host model that reaches the interrupt mask and rate select bank.
 * Assumes the bank shares clk; read results are judged by the bench monitor.
 */
`timescale 1ns/100ps

module host_model (
    input  wire logic        clk,     // Bus clock
    output logic             psel,    // APB select
    output logic             penable, // APB access phase
    output logic             pwrite,  // APB write
    output logic [11:0]      paddr,   // APB byte address
    output logic [31:0]      pwdata,  // APB write data
    input  wire logic        pready   // APB ready
);
    initial begin
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end

    // One byte per word; request held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
endmodule // host_model

// *** tb/testbench.sv ***
/*
 * Self-checking bench for the mask and rate select bank.
 * Assumes the bank answers APB reads with pready; the bench acts as flag logic.
 */
`timescale 1ns/100ps

module testbench;
    logic                    clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic                    interrupt_out_n, irq;
    logic [11:0]             paddr;
    logic [31:0]             pwdata, prdata, m, f, legal;
    logic [7:0]              rx, tx, app;
    logic [8:0]              expq [$];
    logic [8:0]              e;
    logic                    ev;
    int                      fails, checks_done, cyc;
    irq_rate_pkg::flag_set_t latched_flags;
    irq_rate_pkg::rate_out_t rate_sel;
    localparam logic [7:0] REGS [7] = '{8'h57, 8'h58, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68};
    localparam logic [7:0] BITS [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'hF1, 8'hF0};

    host_model HOST (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
                     .paddr(paddr), .pwdata(pwdata), .pready(pready));
    irq_rate_bank DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
                       .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
                       .prdata(prdata), .pslverr(pslverr), .latched_flags(latched_flags),
                       .interrupt_out_n(interrupt_out_n), .irq(irq), .rate_sel(rate_sel));

    ////////////////////////////////////////////////////////////////////////////////
    initial clk = 1'h0;
    always #2 clk = ~clk;

    task automatic stop_test();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done = checks_done + 1;
        if (got !== ex) begin
            fails = fails + 1;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        HOST.xfer(1'h1, idx, d);
    endtask

    // Expected read result is noted before the request goes out
    task automatic rd(input logic [7:0] idx, input logic [7:0] ex, input logic err);
        expq.push_back({err, ex});
        HOST.xfer(1'h0, idx, 8'h00);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails = fails + 1;
            stop_test();
        end
        if (psel && penable && pready && !pwrite) begin
            if (expq.size() == 0) chk("read queue", 32'h1, 32'h0);
            else begin
                e = expq.pop_front();
                chk("prdata", {24'h0, e[7:0]}, prdata);
                chk("pslverr", {31'h0, e[8]}, {31'h0, pslverr});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'h0;
        latched_flags = '0;
        fails = 0;
        checks_done = 0;
        cyc = 0;
        legal = 32'hFF0FF1F0;
        void'($urandom(32'hf24223da));
        repeat (8) @(posedge clk);
        resetn <= 1'h1;
        for (int i = 0; i < 7; i++) rd(REGS[i], 8'h00, 1'h0);
        rd(8'hFF, 8'h00, 1'h1);
        for (int i = 0; i < 7; i++) begin
            wr(REGS[i], 8'hFF);
            rd(REGS[i], BITS[i], 1'h0);
        end
        // Masks against latched flags; first two trials isolate init-complete
        for (int k = 0; k < 10; k++) begin
            m = $urandom;
            f = $urandom & legal;
            if (k < 2) f = 32'h00000100;
            if (k < 2) m = (k == 0) ? 32'h00000000 : 32'h00000100;
            wr(8'h64, m[31:24]);
            wr(8'h65, m[23:16]);
            wr(8'h67, m[15:8]);
            wr(8'h68, m[7:0]);
            latched_flags <= irq_rate_pkg::flag_set_t'(f);
            repeat (3) @(posedge clk);
            chk("interrupt_out_n", {31'h0, ~|(f & ~m & legal)}, {31'h0, interrupt_out_n});
        end
        latched_flags <= '0;
        wr(8'hF0, 8'h09);
        for (int k = 0; k < 4; k++) begin
            rx = (k == 0) ? 8'hE4 : 8'($urandom);
            tx = (k == 0) ? 8'h1B : 8'($urandom);
            app = (k == 0) ? 8'h00 : 8'($urandom & 32'hF);
            wr(8'hF3, app);
            wr(8'h57, rx);
            wr(8'h58, tx);
            rd(8'h57, rx, 1'h0);
            repeat (2) @(posedge clk);
            for (int i = 0; i < 4; i++) begin
                ev = !app[i] && (rx[2*i+:2] != 2'h3);
                chk("rx_valid", {31'h0, ev}, {31'h0, rate_sel.rx_valid[i]});
                chk("rx_code", {30'h0, (app[i] ? 2'h0 : rx[2*i+:2])}, {30'h0, rate_sel.rx[i]});
                ev = !app[i] && (tx[2*i+:2] != 2'h3);
                chk("tx_valid", {31'h0, ev}, {31'h0, rate_sel.tx_valid[i]});
                chk("tx_code", {30'h0, (app[i] ? 2'h0 : tx[2*i+:2])}, {30'h0, rate_sel.tx[i]});
            end
        end
        wr(8'hF0, 8'h0D);
        repeat (2) @(posedge clk);
        chk("rates decl 11", 32'h0, {8'h00, rate_sel});
        wr(8'hF0, 8'h2C);
        rd(8'hF0, 8'h00, 1'h0);
        repeat (2) @(posedge clk);
        chk("rates no support", 32'h0, {8'h00, rate_sel});
        // Event status: sticky, write one to clear, gated by enable
        wr(8'h57, 8'h00);
        wr(8'h58, 8'h00);
        rd(8'hF1, 8'h07, 1'h0);
        wr(8'hF1, 8'h07);
        rd(8'hF1, 8'h00, 1'h0);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'hF2, 8'h02);
        wr(8'h57, 8'h55);
        rd(8'hF1, 8'h02, 1'h0);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'hF1, 8'h02);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'hF2, 8'h00);
        wr(8'h57, 8'h00);
        rd(8'hF1, 8'h02, 1'h0);
        chk("irq", 32'h0, {31'h0, irq});
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule // testbench
